// *** common/slsc_pkg.sv ***
package slsc_pkg;

  localparam int WORD_W    = 16;
  localparam int CODE_W    = 8;
  localparam int RIGHT_LSB = 8;
  localparam int LEFT_LSB  = 0;
  localparam int CH_LEFT   = 0;
  localparam int CH_RIGHT  = 1;
  localparam int N_CH      = 2;

  localparam int CLK_MHZ     = 200;
  localparam int CAL_TIME_US = 2000;
  localparam int ZC_TMO_US   = 18000;
  localparam int CAL_CYC     = CAL_TIME_US * CLK_MHZ;
  localparam int ZC_TMO_CYC  = ZC_TMO_US * CLK_MHZ;
  localparam int CNT_W       = 22;

  localparam int ZC_NEED   = 2;
  localparam int KEEP_BITS = 2;

  localparam logic [CODE_W-1:0] UNITY_CODE = 8'hc0;
  localparam logic [CODE_W-1:0] MUTE_CODE  = 8'h00;
  localparam logic [CODE_W:0]   UNITY_EXT  = {1'b0, UNITY_CODE};
  localparam logic [WORD_W-1:0] LEVEL_RST  = 16'h0000;

  typedef struct packed {
    logic                     soft_mute;
    logic signed [CODE_W:0]   half_db;
    logic        [CODE_W-1:0] code;
  } slsc_chan_t;

  function automatic slsc_chan_t chan_map(input logic [CODE_W-1:0] c);
    slsc_chan_t r;
    r.code      = c;
    r.half_db   = $signed({1'b0, c} - UNITY_EXT);
    r.soft_mute = (c == MUTE_CODE);
    return r;
  endfunction

  localparam slsc_chan_t CHAN_RST = chan_map(MUTE_CODE);

endpackage

// *** hw/slsc_shift.sv ***
module slsc_shift (
  input  wire logic                       sclk_i,
  input  wire logic                       srst_i,
  input  wire logic                       select_n_i,
  input  wire logic                       serial_in_i,
  input  wire logic                       clr_tgl_i,
  output logic      [slsc_pkg::WORD_W-1:0] word_o,
  output logic                            serial_out_o
);

  typedef struct packed {
    logic [1:0]                  rst_s;
    logic [1:0]                  clr_s;
    logic                        clr_ack;
    logic                        carry;
    logic [slsc_pkg::WORD_W-1:0] sr;
  } slsc_shift_st_t;

  slsc_shift_st_t q;
  slsc_shift_st_t d;
  logic           out_q;

  // A pending clear keeps only the bits this frame has already shifted in.
  always_comb begin
    d       = q;
    d.rst_s = {q.rst_s[0], srst_i};
    d.clr_s = {q.clr_s[0], clr_tgl_i};
    // The link clock stops after reset, so the synced reset clears only while idle;
    // otherwise the first frame after reset would lose its opening bits.
    if (q.rst_s[1] && select_n_i) begin
      d.sr      = slsc_pkg::LEVEL_RST;
      d.carry   = 1'b0;
      d.clr_ack = q.clr_s[1];
    end else if (!select_n_i) begin
      d.carry = q.sr[slsc_pkg::WORD_W-1];
      d.sr    = {q.sr[slsc_pkg::WORD_W-2:0], serial_in_i};
      if (q.clr_s[1] != q.clr_ack) begin
        d.sr      = {{(slsc_pkg::WORD_W-slsc_pkg::KEEP_BITS-1){1'b0}},
                     q.sr[slsc_pkg::KEEP_BITS-1:0], serial_in_i};
        d.clr_ack = q.clr_s[1];
      end
    end
  end

  always_ff @(posedge sclk_i) begin
    q <= d;
  end

  // The outgoing bit changes on the falling edge so the next device samples it cleanly.
  always_ff @(negedge sclk_i) begin
    if (q.rst_s[1] && select_n_i) begin
      out_q <= 1'b0;
    end else if (!select_n_i) begin
      out_q <= q.carry;
    end
  end

  assign word_o       = q.sr;
  assign serial_out_o = out_q;

  property p_shift_in;
    @(posedge sclk_i) disable iff (q.rst_s[1])
    !select_n_i && (q.clr_s[1] == q.clr_ack) |=> q.sr[0] == $past(serial_in_i);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("serial input bit not shifted in");

  property p_carry;
    @(posedge sclk_i) disable iff (q.rst_s[1])
    !select_n_i |=> q.carry == $past(q.sr[slsc_pkg::WORD_W-1]);
  endproperty
  a_carry: assert property (p_carry) else $error("old word bit not passed toward output");

  property p_out_fall;
    @(negedge sclk_i) disable iff (q.rst_s[1])
    !select_n_i |=> serial_out_o == $past(q.carry);
  endproperty
  a_out_fall: assert property (p_out_fall) else $error("serial output not updated on fall");

endmodule

// *** hw/slsc_chan.sv ***
module slsc_chan #(
  parameter int TMO_CYC = slsc_pkg::ZC_TMO_CYC
) (
  input  wire logic                        clk_i,
  input  wire logic                        srst_i,
  input  wire logic                        clear_i,
  input  wire logic                        load_i,
  input  wire logic [slsc_pkg::CODE_W-1:0] code_i,
  input  wire logic                        zce_i,
  input  wire logic                        zc_i,
  output slsc_pkg::slsc_chan_t             out_o
);

  typedef struct packed {
    logic                        pend;
    logic [slsc_pkg::CODE_W-1:0] code;
    logic [1:0]                  zc_cnt;
    logic [slsc_pkg::CNT_W-1:0]  tmr;
    slsc_pkg::slsc_chan_t        out;
  } slsc_chan_st_t;

  localparam slsc_chan_st_t ST_RST = '{
    pend: 1'b0, code: slsc_pkg::MUTE_CODE, zc_cnt: 2'h0, tmr: '0, out: slsc_pkg::CHAN_RST};
  localparam logic [slsc_pkg::CNT_W-1:0] TMO_LAST = slsc_pkg::CNT_W'(TMO_CYC - 1);
  localparam logic [1:0]                 ZC_LAST  = 2'(slsc_pkg::ZC_NEED - 1);

  slsc_chan_st_t q;
  slsc_chan_st_t d;

  always_comb begin
    logic apply;
    apply = 1'b0;
    d     = q;
    if (q.pend) begin
      d.tmr = q.tmr + 1'b1;
      if (zc_i) begin
        d.zc_cnt = q.zc_cnt + 2'h1;
      end
      apply = !zce_i || (zc_i && q.zc_cnt == ZC_LAST) || (q.tmr == TMO_LAST);
    end
    if (apply) begin
      d.out  = slsc_pkg::chan_map(q.code);
      d.pend = 1'b0;
    end
    // A new level restarts both the crossing count and the timeout.
    if (load_i) begin
      d.pend   = 1'b1;
      d.code   = code_i;
      d.zc_cnt = 2'h0;
      d.tmr    = '0;
    end
    if (clear_i) begin
      d.pend = 1'b0;
      d.out  = slsc_pkg::CHAN_RST;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  assign out_o = q.out;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  property p_nozc;
    load_i && !clear_i && !zce_i ##1 !zce_i && !clear_i && !load_i
    |=> q.out.code == $past(code_i, 2);
  endproperty
  a_nozc: assert property (p_nozc) else $error("level not applied at once with crossing off");

  property p_tmo;
    q.pend && zce_i && !load_i && !clear_i && q.tmr == TMO_LAST
    |=> !q.pend && q.out.code == $past(q.code);
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout did not apply level");

  property p_zc_wait;
    q.pend && zce_i && !load_i && !clear_i && q.zc_cnt == 2'h0 && q.tmr != TMO_LAST
    |=> q.pend;
  endproperty
  a_zc_wait: assert property (p_zc_wait) else $error("level applied before two crossings");

  property p_map;
    q.out.soft_mute == (q.out.code == slsc_pkg::MUTE_CODE) &&
    ((q.out.code != slsc_pkg::UNITY_CODE) || (q.out.half_db == '0));
  endproperty
  a_map: assert property (p_map) else $error("channel code mapping wrong");

  c_zc_apply: cover property (q.pend && zce_i && zc_i && q.zc_cnt == ZC_LAST);

endmodule

// *** hw/slsc_top.sv ***
// Summary of operation
// - A level transfer is one sixteen-bit word per device shifted into the serial input.
// - The first eight bits shifted in form the right channel level code.
// - The second eight bits shifted in form the left channel level code.
// - The serial input is sampled on each rising serial clock edge while select is low.
// - The serial output changes on each falling serial clock edge during a transfer.
// - The serial output replays the sixteen bits that were shifted in before.
// - The serial output floats whenever the active-low select is high.
// - Select falling starts a new word and comes before the first serial clock.
// - Select rising copies the shift register into the level register.
// - While mute is low both analog outputs are forced to ground.
// - A falling edge on mute starts an offset calibration.
// - Zero-cross enable high waits for crossings or timeout, low applies levels at once.
// - Each code maps in half-decibel steps, 0xc0 unity, zero meaning software mute.
// - With crossings enabled a new level applies after two crossings or 18 ms.
// - The mute power-up sequence clears the level register, and the shift register on the third serial clock of the next transfer except its first two bits.
module slsc_top #(
  parameter int CAL_CYC    = slsc_pkg::CAL_CYC,
  parameter int ZC_TMO_CYC = slsc_pkg::ZC_TMO_CYC
) (
  input  wire logic                        clock_i,
  input  wire logic                        srst_i,
  input  wire logic                        sclk_i,
  input  wire logic                        select_n_i,
  input  wire logic                        serial_in_i,
  output logic                             serial_out_o,
  output logic                             serial_out_oe_o,
  input  wire logic                        mute_n_i,
  input  wire logic                        zero_cross_enable_i,
  input  wire logic                        zero_cross_left_i,
  input  wire logic                        zero_cross_right_i,
  output slsc_pkg::slsc_chan_t             left_analog_out_o,
  output slsc_pkg::slsc_chan_t             right_analog_out_o,
  output logic                             outputs_grounded_o,
  output logic                             cal_busy_o,
  output logic      [slsc_pkg::WORD_W-1:0] level_word_o
);

  typedef struct packed {
    logic [2:0]                             sel_s;
    logic [2:0]                             mute_s;
    logic [1:0]                             zce_s;
    logic [slsc_pkg::N_CH-1:0][2:0]          zc_s;
    logic [slsc_pkg::WORD_W-1:0]             level;
    logic                                   lat;
    logic                                   clr_tgl;
    logic                                   oe;
    logic                                   grounded;
    logic                                   cal_busy;
    logic [slsc_pkg::CNT_W-1:0]              cal_cnt;
  } slsc_top_st_t;

  localparam slsc_top_st_t ST_RST = '{
    sel_s:    3'h7,
    mute_s:   3'h7,
    zce_s:    2'h0,
    zc_s:     '0,
    level:    slsc_pkg::LEVEL_RST,
    lat:      1'b0,
    clr_tgl:  1'b0,
    oe:       1'b0,
    grounded: 1'b0,
    cal_busy: 1'b0,
    cal_cnt:  '0
  };

  localparam logic [slsc_pkg::CNT_W-1:0] CAL_LAST = slsc_pkg::CNT_W'(CAL_CYC - 1);

  slsc_top_st_t                q;
  slsc_top_st_t                d;
  logic [slsc_pkg::WORD_W-1:0] shift_word;
  logic                        sel_rise;
  logic                        mute_fall;
  logic [slsc_pkg::N_CH-1:0]   zc_pins;
  logic [slsc_pkg::N_CH-1:0]   zc_edge;
  slsc_pkg::slsc_chan_t        chan_out [slsc_pkg::N_CH];

  assign zc_pins[slsc_pkg::CH_LEFT]  = zero_cross_left_i;
  assign zc_pins[slsc_pkg::CH_RIGHT] = zero_cross_right_i;

  // Edges are taken between the second and third stages, never from the first.
  assign sel_rise  = q.sel_s[1] && !q.sel_s[2];
  assign mute_fall = !q.mute_s[1] && q.mute_s[2];

  // The shift register lives on the serial clock; it is only read here once
  // select has been high for two system cycles, when that clock stands still.
  slsc_shift u_shift (
    .sclk_i       (sclk_i),
    .srst_i       (srst_i),
    .select_n_i   (select_n_i),
    .serial_in_i  (serial_in_i),
    .clr_tgl_i    (q.clr_tgl),
    .word_o       (shift_word),
    .serial_out_o (serial_out_o)
  );

  always_comb begin
    d        = q;
    d.sel_s  = {q.sel_s[1:0], select_n_i};
    d.mute_s = {q.mute_s[1:0], mute_n_i};
    d.zce_s  = {q.zce_s[0], zero_cross_enable_i};
    for (int i = 0; i < slsc_pkg::N_CH; i++) begin
      d.zc_s[i] = {q.zc_s[i][1:0], zc_pins[i]};
    end

    d.oe       = !q.sel_s[1];
    d.grounded = !q.mute_s[1];

    d.lat = sel_rise;
    if (sel_rise) begin
      d.level = shift_word;
    end

    if (q.cal_busy) begin
      d.cal_cnt = q.cal_cnt + 1'b1;
      if (q.cal_cnt == CAL_LAST) begin
        d.cal_busy = 1'b0;
      end
    end

    // Mute wins over a latch in the same cycle: the power-up clear must hold.
    if (mute_fall) begin
      d.level    = slsc_pkg::LEVEL_RST;
      d.lat      = 1'b0;
      d.clr_tgl  = !q.clr_tgl;
      d.cal_busy = 1'b1;
      d.cal_cnt  = '0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  for (genvar i = 0; i < slsc_pkg::N_CH; i++) begin : g_chan
    assign zc_edge[i] = q.zc_s[i][1] ^ q.zc_s[i][2];

    // Channel 0 takes the low byte (left), channel 1 the high byte (right).
    slsc_chan #(
      .TMO_CYC (ZC_TMO_CYC)
    ) u_chan (
      .clk_i   (clock_i),
      .srst_i  (srst_i),
      .clear_i (mute_fall),
      .load_i  (q.lat),
      .code_i  (q.level[i*slsc_pkg::CODE_W +: slsc_pkg::CODE_W]),
      .zce_i   (q.zce_s[1]),
      .zc_i    (zc_edge[i]),
      .out_o   (chan_out[i])
    );
  end

  assign left_analog_out_o  = chan_out[slsc_pkg::CH_LEFT];
  assign right_analog_out_o = chan_out[slsc_pkg::CH_RIGHT];
  assign serial_out_oe_o    = q.oe;
  assign outputs_grounded_o = q.grounded;
  assign cal_busy_o         = q.cal_busy;
  assign level_word_o       = q.level;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  property p_latch;
    sel_rise && !mute_fall |=> q.lat && q.level == $past(shift_word);
  endproperty
  a_latch: assert property (p_latch) else $error("word not latched on select rise");

  property p_right;
    q.lat && !q.zce_s[1] && !mute_fall ##1 !q.zce_s[1] && !mute_fall
    |=> right_analog_out_o.code == $past(q.level[slsc_pkg::RIGHT_LSB +: slsc_pkg::CODE_W], 2);
  endproperty
  a_right: assert property (p_right) else $error("right code not from first byte");

  property p_left;
    q.lat && !q.zce_s[1] && !mute_fall ##1 !q.zce_s[1] && !mute_fall
    |=> left_analog_out_o.code == $past(q.level[slsc_pkg::LEFT_LSB +: slsc_pkg::CODE_W], 2);
  endproperty
  a_left: assert property (p_left) else $error("left code not from second byte");

  property p_float;
    q.sel_s[1] |=> !serial_out_oe_o;
  endproperty
  a_float: assert property (p_float) else $error("serial output driven with select high");

  property p_drive;
    !q.sel_s[1] ##1 !q.sel_s[1] |-> serial_out_oe_o;
  endproperty
  a_drive: assert property (p_drive) else $error("serial output not driven in frame");

  property p_ground;
    !q.mute_s[1] |=> outputs_grounded_o;
  endproperty
  a_ground: assert property (p_ground) else $error("outputs not grounded under mute");

  property p_cal_start;
    mute_fall |=> cal_busy_o && q.cal_cnt == '0;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("calibration not started");

  property p_cal_end;
    q.cal_busy && q.cal_cnt == CAL_LAST && !mute_fall |=> !cal_busy_o;
  endproperty
  a_cal_end: assert property (p_cal_end) else $error("calibration did not end on time");

  property p_clear;
    mute_fall |=> level_word_o == slsc_pkg::LEVEL_RST && q.clr_tgl != $past(q.clr_tgl)
      ##1 left_analog_out_o.code == slsc_pkg::MUTE_CODE;
  endproperty
  a_clear: assert property (p_clear) else $error("power-up clear incomplete");

  property p_lat_src;
    !sel_rise |=> !q.lat;
  endproperty
  a_lat_src: assert property (p_lat_src) else $error("latch with no select rise");

  property p_lat_pulse;
    q.lat |=> !q.lat;
  endproperty
  a_lat_pulse: assert property (p_lat_pulse) else $error("latch strobe too long");

  property p_level_hold;
    !sel_rise && !mute_fall |=> $stable(level_word_o);
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("level word changed alone");

  property p_oe_latch;
    sel_rise |-> serial_out_oe_o ##1 !serial_out_oe_o;
  endproperty
  a_oe_latch: assert property (p_oe_latch) else $error("enable wrong at latch");

  property p_oe_frame;
    !q.sel_s[1] |=> serial_out_oe_o;
  endproperty
  a_oe_frame: assert property (p_oe_frame) else $error("enable late in frame");

  property p_unground;
    q.mute_s[1] |=> !outputs_grounded_o;
  endproperty
  a_unground: assert property (p_unground) else $error("grounded without mute");

  property p_cal_idle;
    !q.cal_busy && !mute_fall |=> !cal_busy_o;
  endproperty
  a_cal_idle: assert property (p_cal_idle) else $error("calibration started alone");

  property p_cal_step;
    q.cal_busy && !mute_fall && q.cal_cnt != CAL_LAST
    |=> cal_busy_o && q.cal_cnt == $past(q.cal_cnt) + 1'b1;
  endproperty
  a_cal_step: assert property (p_cal_step) else $error("calibration count skipped");

  property p_cal_bound;
    cal_busy_o |-> q.cal_cnt <= CAL_LAST;
  endproperty
  a_cal_bound: assert property (p_cal_bound) else $error("calibration overran");

  property p_cal_rose;
    $rose(cal_busy_o) |-> $past(mute_fall);
  endproperty
  a_cal_rose: assert property (p_cal_rose) else $error("calibration without mute");

  property p_mute_once;
    mute_fall |=> !mute_fall;
  endproperty
  a_mute_once: assert property (p_mute_once) else $error("mute edge seen twice");

  property p_mute_lat;
    mute_fall |=> !q.lat;
  endproperty
  a_mute_lat: assert property (p_mute_lat) else $error("latch beat the mute clear");

  property p_clr_hold;
    !mute_fall |=> $stable(q.clr_tgl);
  endproperty
  a_clr_hold: assert property (p_clr_hold) else $error("shift clear sent alone");

  property p_chan_clr;
    mute_fall |=> right_analog_out_o.code == slsc_pkg::MUTE_CODE &&
      left_analog_out_o.code == slsc_pkg::MUTE_CODE;
  endproperty
  a_chan_clr: assert property (p_chan_clr) else $error("channels not cleared");

  property p_right_map;
    right_analog_out_o.soft_mute == (right_analog_out_o.code == slsc_pkg::MUTE_CODE) &&
    right_analog_out_o.half_db == {1'b0, right_analog_out_o.code} - slsc_pkg::UNITY_EXT;
  endproperty
  a_right_map: assert property (p_right_map) else $error("right code map wrong");

  property p_left_map;
    left_analog_out_o.soft_mute == (left_analog_out_o.code == slsc_pkg::MUTE_CODE) &&
    left_analog_out_o.half_db == {1'b0, left_analog_out_o.code} - slsc_pkg::UNITY_EXT;
  endproperty
  a_left_map: assert property (p_left_map) else $error("left code map wrong");

  c_latch:    cover property (sel_rise ##1 q.lat);
  c_mute:     cover property (mute_fall ##1 outputs_grounded_o);
  c_cal_done: cover property (q.cal_busy ##1 !q.cal_busy);
  c_zc_mode:  cover property (q.lat && q.zce_s[1]);

endmodule

// *** bench/slsc_host_model.sv ***
module slsc_host_model (
  output logic      sclk_o,
  output logic      select_n_o,
  output logic      serial_in_o,
  input  wire logic serial_out_i,
  input  wire logic serial_out_oe_i
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam realtime HALF = 7.5;

  logic last_q;
  logic line;

  // A released output no longer shows its last bit, so the host sees the inverse.
  always @(serial_out_oe_i or serial_out_i) if (serial_out_oe_i) last_q = serial_out_i;
  assign line = serial_out_oe_i ? serial_out_i : ~last_q;

  initial begin
    sclk_o      = 1'b0;
    select_n_o  = 1'b1;
    serial_in_o = 1'b0;
  end

  task automatic pulse(input int n);
    repeat (n) begin
      #HALF sclk_o = 1'b1;
      #HALF sclk_o = 1'b0;
    end
  endtask

  // Data changes while the clock is low, away from the sampling edge.
  task automatic send_word(input logic [15:0] w, output logic [15:0] rd);
    select_n_o = 1'b0;
    for (int k = 0; k < 16; k++) begin
      serial_in_o = w[15-k];
      #HALF;
      if (k > 0) rd[16-k] = line;
      sclk_o = 1'b1;
      #HALF;
      sclk_o = 1'b0;
    end
    #HALF;
    rd[0]       = line;
    select_n_o  = 1'b1;
    serial_in_o = ~serial_in_o;
    #30;
  endtask
endmodule

// *** bench/slsc_tb_top.sv ***
module slsc_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int CAL_N = 20;
  localparam int TMO_N = 50;

  typedef struct packed {
    logic [15:0] word;
    logic        zce;
  } slsc_note_t;

  logic                 clock_i = 1'b0;
  logic                 srst_i;
  logic                 mute_n_i;
  logic                 zce;
  logic                 zcl;
  logic                 zcr;
  logic                 sclk;
  logic                 select_n;
  logic                 serial_in;
  logic                 serial_out;
  logic                 serial_out_oe;
  logic                 grounded;
  logic                 cal_busy;
  logic [15:0]          level_word;
  slsc_pkg::slsc_chan_t left_out;
  slsc_pkg::slsc_chan_t right_out;
  int                   n_errors = 0;
  int                   checks = 0;
  int                   seed = 32'h347a;
  slsc_note_t           notes[$];
  slsc_note_t           note;

  always #2.5 clock_i = ~clock_i;

  slsc_top #(.CAL_CYC(CAL_N), .ZC_TMO_CYC(TMO_N)) DUT (
    .clock_i            (clock_i),
    .srst_i             (srst_i),
    .sclk_i             (sclk),
    .select_n_i         (select_n),
    .serial_in_i        (serial_in),
    .serial_out_o       (serial_out),
    .serial_out_oe_o    (serial_out_oe),
    .mute_n_i           (mute_n_i),
    .zero_cross_enable_i(zce),
    .zero_cross_left_i  (zcl),
    .zero_cross_right_i (zcr),
    .left_analog_out_o  (left_out),
    .right_analog_out_o (right_out),
    .outputs_grounded_o (grounded),
    .cal_busy_o         (cal_busy),
    .level_word_o       (level_word)
  );

  slsc_host_model host (
    .sclk_o         (sclk),
    .select_n_o     (select_n),
    .serial_in_o    (serial_in),
    .serial_out_i   (serial_out),
    .serial_out_oe_i(serial_out_oe)
  );

  task automatic test_done();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic slsc_pkg::slsc_chan_t exp_chan(input logic [7:0] c);
    exp_chan = {c == 8'h00, {1'b0, c} - 9'h0c0, c};
  endfunction

  task automatic chk_chan(input logic [7:0] r, input logic [7:0] l);
    check("right_out", right_out, exp_chan(r));
    check("left_out", left_out, exp_chan(l));
  endtask

  task automatic frame(input logic [15:0] w, output logic [15:0] rd);
    notes.push_back('{w, zce});
    fork
      host.send_word(w, rd);
      begin
        repeat (10) @(negedge clock_i);
        check("oe_in_frame", serial_out_oe, 1'b1);
      end
    join
    repeat (6) @(negedge clock_i);
  endtask

  // Each frame end releases the output; the latched word is then compared with the oldest note.
  always begin
    @(negedge serial_out_oe);
    repeat (4) @(negedge clock_i);
    if (notes.size() != 0) begin
      note = notes.pop_front();
      check("oe_idle", serial_out_oe, 1'b0);
      check("level_word", level_word, note.word);
      if (!note.zce) chk_chan(note.word[15:8], note.word[7:0]);
    end
  end

  initial begin
    #40us;
    n_errors++;
    $display("ERROR watchdog expected done seen timeout");
    test_done();
  end

  initial begin
    logic [15:0] rd;
    logic [15:0] prev;
    logic [15:0] w;
    int          n;
    srst_i   = 1'b1;
    mute_n_i = 1'b1;
    zce      = 1'b0;
    zcl      = 1'b0;
    zcr      = 1'b0;
    fork
      repeat (5) @(negedge clock_i);
      host.pulse(4);
    join
    @(negedge clock_i);
    srst_i = 1'b0;
    repeat (6) @(negedge clock_i);
    check("level_rst", level_word, 16'h0000);
    chk_chan(8'h00, 8'h00);
    check("flags_rst", {serial_out_oe, grounded, cal_busy}, 3'b000);
    $display("test reset done");
    prev = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      w = (i == 0) ? 16'hc000 : (i == 1) ? 16'h00c0 : (i == 2) ? 16'hff01 : 16'($random(seed));
      frame(w, rd);
      check("readback", rd, prev);
      prev = w;
    end
    $display("test serial done");
    zce = 1'b1;
    repeat (4) @(negedge clock_i);
    w = 16'h3c5a;
    frame(w, rd);
    check("readback", rd, prev);
    chk_chan(prev[15:8], prev[7:0]);
    zcl = ~zcl;
    repeat (5) @(negedge clock_i);
    check("left_one_zc", left_out, exp_chan(prev[7:0]));
    zcl = ~zcl;
    repeat (5) @(negedge clock_i);
    check("left_two_zc", left_out, exp_chan(w[7:0]));
    check("right_wait", right_out, exp_chan(prev[15:8]));
    repeat (TMO_N) @(negedge clock_i);
    check("right_tmo", right_out, exp_chan(w[15:8]));
    zce = 1'b0;
    $display("test crossing done");
    mute_n_i = 1'b0;
    repeat (6) @(negedge clock_i);
    check("mute_flags", {grounded, cal_busy}, 2'b11);
    check("mute_level", level_word, 16'h0000);
    chk_chan(8'h00, 8'h00);
    n = 0;
    while (cal_busy === 1'b1 && n < 100) begin
      @(negedge clock_i);
      n++;
    end
    // Three busy cycles have passed before the count starts.
    check("cal_len", n, CAL_N - 3);
    repeat (5) @(negedge clock_i);
    mute_n_i = 1'b1;
    repeat (6) @(negedge clock_i);
    check("unmute", grounded, 1'b0);
    frame(16'($random(seed)), rd);
    check("cleared_shift", rd[12:0], 13'h0000);
    $display("test mute done");
    test_done();
  end
endmodule
